// *** inc/iocm_pkg.sv ***
// Overview of operation
// - Ports 5 to 8 may switch their second-channel aux supply pin as an extra digital output.
// - Every output channel keeps its own blanking delay setting, applied before current monitoring starts.
// - The blanking delay starts on every output edge, rising or falling.
// - After the delay expires the channel is monitored and a detected fault raises a diagnostic event.
// - Blanking delay settings run from 0 to 255 ms in whole milliseconds.
// - Every blanking delay setting is 80 ms after reset.
// - While an output stays static, faults are reacted to after a 5 ms interval instead.
// - Each channel used as a digital input has a normally-open or normally-closed polarity, except on the small variant, which passes every input unchanged.
// - Every input polarity is normally open after reset.
// - Normally-open passes the pin level unchanged.
// - Normally-closed inverts the pin level.
// - Each port's second channel selects input, aux power, output or inactive.
// - On the small variant the second-channel mode is fixed: ports 1-4 input, ports 5-8 aux power.
package iocm_pkg;
	localparam int unsigned CLK_HZ        = 200000000;
	localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
	localparam int unsigned STATIC_MS     = 5;
	localparam logic [7:0]  BLANK_RST     = 8'h50;
	localparam int unsigned NPORT         = 8;
	localparam int unsigned FIRST_AUX_OUT = 4;
	localparam logic [11:0] ADDR_POLARITY = 12'h000;
	localparam logic [11:0] ADDR_MODE     = 12'h004;
	localparam logic [11:0] ADDR_OUTPUT   = 12'h008;
	localparam logic [11:0] ADDR_STATUS   = 12'h00C;
	localparam logic [11:0] ADDR_INPUT    = 12'h010;
	localparam logic [11:0] ADDR_DIAG     = 12'h014;
	localparam logic [11:0] ADDR_BLANK0   = 12'h020;
	localparam logic [11:0] ADDR_BLANK1   = 12'h024;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef enum logic [1:0] {
		MODE_INPUT    = 2'h0,
		MODE_AUX_PASS = 2'h1,
		MODE_OUTPUT   = 2'h2,
		MODE_INACTIVE = 2'h3
	} iocm_mode_t;
endpackage : iocm_pkg

// *** core/iocm_blank.sv ***
`timescale 1ns/1ps
module iocm_blank (
	input  wire logic       aclk,      // Module clock.
	input  wire logic       aresetn,   // Synchronous reset, active low.
	input  wire logic       ms_tick,   // One-cycle millisecond tick.
	input  wire logic       out_level, // Driven output level.
	input  wire logic [7:0] delay_ms,  // Blanking delay setting.
	input  wire logic       fault,     // Raw current fault.
	output logic            armed,     // Monitoring enabled.
	output logic            diag_evt   // One-cycle diagnostic event.
);
	logic       out_prev_reg;
	logic [7:0] blank_cnt_reg;
	logic [2:0] react_cnt_reg;
	logic       fault_seen_reg;
	logic       edge_det;

	assign edge_det = out_level != out_prev_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) out_prev_reg <= 1'b0;
		else          out_prev_reg <= out_level;
	end

	// The count restarts on every edge, so a toggling output stays blanked.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blank_cnt_reg <= 8'h00;
		end else if (edge_det) begin
			blank_cnt_reg <= delay_ms;
		end else if (ms_tick && blank_cnt_reg != 8'h00) begin
			blank_cnt_reg <= blank_cnt_reg - 8'h01;
		end
	end

	assign armed = !edge_det && blank_cnt_reg == 8'h00;

	// Static channel: a fault must persist over the reaction interval.
	always_ff @(posedge aclk) begin
		if (!aresetn || !armed || !fault) begin
			react_cnt_reg <= 3'h0;
		end else if (ms_tick && react_cnt_reg != 3'(iocm_pkg::STATIC_MS)) begin
			react_cnt_reg <= react_cnt_reg + 3'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !armed || !fault) fault_seen_reg <= 1'b0;
		else if (react_cnt_reg == 3'(iocm_pkg::STATIC_MS)) fault_seen_reg <= 1'b1;
	end

	assign diag_evt = armed && fault && !fault_seen_reg
		&& react_cnt_reg == 3'(iocm_pkg::STATIC_MS);
endmodule : iocm_blank

// *** core/iocm_top.sv ***
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module iocm_top #(
	parameter int unsigned MS_CYCLES = iocm_pkg::MS_CYCLES, // Clock cycles per millisecond.
	parameter bit          FIXED_MODE = 1'b0                // Small variant with fixed modes.
) (
	input  wire logic        aclk,          // Module clock.
	input  wire logic        aresetn,       // Synchronous reset, active low.
	input  wire logic [11:0] s_awaddr,      // Write address.
	input  wire logic        s_awvalid,     // Write address valid.
	output logic             s_awready,     // Write address ready.
	input  wire logic [31:0] s_wdata,       // Write data.
	input  wire logic [3:0]  s_wstrb,       // Write strobes.
	input  wire logic        s_wvalid,      // Write data valid.
	output logic             s_wready,      // Write data ready.
	output logic [1:0]       s_bresp,       // Write response.
	output logic             s_bvalid,      // Write response valid.
	input  wire logic        s_bready,      // Write response ready.
	input  wire logic [11:0] s_araddr,      // Read address.
	input  wire logic        s_arvalid,     // Read address valid.
	output logic             s_arready,     // Read address ready.
	output logic [31:0]      s_rdata,       // Read data.
	output logic [1:0]       s_rresp,       // Read response.
	output logic             s_rvalid,      // Read data valid.
	input  wire logic        s_rready,      // Read data ready.
	input  wire logic [15:0] pin_in,        // Input levels, first channels in bits 7:0, second channels in bits 15:8.
	output logic [7:0]       aux_supply_pin,// Aux supply pin drive per port.
	input  wire logic [7:0]  aux_fault,     // Aux supply overcurrent per port.
	output logic [15:0]      input_value,   // Polarity-corrected inputs.
	output logic [7:0]       diag_pulse     // One-cycle diagnostic events.
);
	localparam int unsigned NP = iocm_pkg::NPORT;
	localparam int unsigned NO = NP - iocm_pkg::FIRST_AUX_OUT;

	// The tick counter wraps at MS_CYCLES - 1, so a period of one cycle would tick on every clock.
	if (MS_CYCLES < 2) begin : g_bad_ms_cycles
		$error("MS_CYCLES must be at least 2");
	end

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [15:0]       pol_reg;
	logic [15:0]       mode_reg;
	logic [7:0]        out_reg;
	logic [7:0]        diag_reg;
	logic [7:0]        blank_reg [NO];
	logic [15:0]       input_reg;
	logic [31:0]       tick_cnt_reg;
	logic              ms_tick;
	wire logic [7:0]   armed;
	wire logic [7:0]   evt;
	logic              aw_held_reg;
	logic              w_held_reg;
	logic [11:0]       awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              wr_go;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction : merge

	function automatic iocm_pkg::iocm_mode_t port_mode(input int p, input logic [15:0] m);
		if (FIXED_MODE)
			return (p < int'(iocm_pkg::FIRST_AUX_OUT)) ? iocm_pkg::MODE_INPUT : iocm_pkg::MODE_AUX_PASS;
		return iocm_pkg::iocm_mode_t'(m[2*p +: 2]);
	endfunction : port_mode

	// ----------------------------------------------------------------
	// Millisecond tick
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || tick_cnt_reg == MS_CYCLES - 1) tick_cnt_reg <= 32'h00000000;
		else tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
	end
	assign ms_tick = tick_cnt_reg == MS_CYCLES - 1;

	// ----------------------------------------------------------------
	// AXI4-Lite write
	// ----------------------------------------------------------------
	assign s_awready = !aw_held_reg && !s_bvalid;
	assign s_wready  = !w_held_reg && !s_bvalid;
	assign wr_go     = aw_held_reg && w_held_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= 12'h000;
		end else if (s_awvalid && s_awready) begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= s_awaddr;
		end else if (wr_go) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= 32'h00000000;
			wstrb_reg  <= 4'h0;
		end else if (s_wvalid && s_wready) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= s_wdata;
			wstrb_reg  <= s_wstrb;
		end else if (wr_go) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_bvalid <= 1'b0;
			s_bresp  <= iocm_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_bvalid <= 1'b1;
			unique case (awaddr_reg)
				iocm_pkg::ADDR_POLARITY, iocm_pkg::ADDR_MODE, iocm_pkg::ADDR_OUTPUT,
				iocm_pkg::ADDR_DIAG, iocm_pkg::ADDR_BLANK0, iocm_pkg::ADDR_BLANK1:
					s_bresp <= iocm_pkg::RESP_OKAY;
				default: s_bresp <= iocm_pkg::RESP_SLVERR;
			endcase
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		logic [31:0] m;
		m = 32'h00000000;
		if (!aresetn) begin
			pol_reg  <= 16'h0000;
			mode_reg <= 16'h0000;
			out_reg  <= 8'h00;
		end else if (wr_go) begin
			if (awaddr_reg == iocm_pkg::ADDR_POLARITY) begin
				m = merge({16'h0000, pol_reg}, wdata_reg, wstrb_reg);
				pol_reg <= m[15:0];
			end
			if (awaddr_reg == iocm_pkg::ADDR_MODE) begin
				m = merge({16'h0000, mode_reg}, wdata_reg, wstrb_reg);
				mode_reg <= m[15:0];
			end
			if (awaddr_reg == iocm_pkg::ADDR_OUTPUT) out_reg <= wstrb_reg[0] ? wdata_reg[7:0] : out_reg;
		end
	end

	// Blanking settings: 8 bits each, all 0..255 values legal.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < int'(NO); i++) blank_reg[i] <= iocm_pkg::BLANK_RST;
		end else if (wr_go) begin
			for (int i = 0; i < int'(NO); i++)
				if (wstrb_reg[i] && awaddr_reg == iocm_pkg::ADDR_BLANK0)
					blank_reg[i] <= wdata_reg[8*i +: 8];
		end
	end

	// Diagnostic bits are sticky; a new event wins over a clear in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) diag_reg <= 8'h00;
		else if (wr_go && awaddr_reg == iocm_pkg::ADDR_DIAG && wstrb_reg[0])
			diag_reg <= (diag_reg & ~wdata_reg[7:0]) | evt;
		else diag_reg <= diag_reg | evt;
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read
	// ----------------------------------------------------------------
	assign s_arready = !s_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h00000000;
			s_rresp  <= iocm_pkg::RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp  <= iocm_pkg::RESP_OKAY;
			unique case (s_araddr)
				iocm_pkg::ADDR_POLARITY: s_rdata <= {16'h0000, pol_reg};
				iocm_pkg::ADDR_MODE:     s_rdata <= {16'h0000, mode_reg};
				iocm_pkg::ADDR_OUTPUT:   s_rdata <= {24'h000000, out_reg};
				iocm_pkg::ADDR_STATUS:   s_rdata <= {16'h0000, aux_supply_pin, armed};
				iocm_pkg::ADDR_INPUT:    s_rdata <= {16'h0000, input_reg};
				iocm_pkg::ADDR_DIAG:     s_rdata <= {24'h000000, diag_reg};
				iocm_pkg::ADDR_BLANK0:   s_rdata <= {blank_reg[3], blank_reg[2], blank_reg[1], blank_reg[0]};
				iocm_pkg::ADDR_BLANK1:   s_rdata <= 32'h00000000;
				default: begin
					s_rdata <= 32'h00000000;
					s_rresp <= iocm_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Input polarity
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) input_reg <= 16'h0000;
		else begin
			for (int c = 0; c < 16; c++) begin
				if (c >= int'(NP) && port_mode(c - int'(NP), mode_reg) != iocm_pkg::MODE_INPUT)
					input_reg[c] <= 1'b0;
				else
					input_reg[c] <= pin_in[c] ^ (FIXED_MODE ? 1'b0 : pol_reg[c]);
			end
		end
	end
	assign input_value = input_reg;

	// ----------------------------------------------------------------
	// Second-channel aux supply pins
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) aux_supply_pin <= 8'h00;
		else begin
			for (int p = 0; p < int'(NP); p++) begin
				unique case (port_mode(p, mode_reg))
					iocm_pkg::MODE_AUX_PASS: aux_supply_pin[p] <= 1'b1;
					iocm_pkg::MODE_OUTPUT:
						aux_supply_pin[p] <= (p >= int'(iocm_pkg::FIRST_AUX_OUT)) && out_reg[p];
					default: aux_supply_pin[p] <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Monitoring per switchable output
	// ----------------------------------------------------------------
	assign armed[iocm_pkg::FIRST_AUX_OUT-1:0] = '0;
	assign evt[iocm_pkg::FIRST_AUX_OUT-1:0]   = '0;

	for (genvar g = 0; g < int'(NO); g++) begin : g_out
		localparam int P = g + int'(iocm_pkg::FIRST_AUX_OUT);
		iocm_blank i_iocm_blank (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.ms_tick   (ms_tick),
			.out_level (aux_supply_pin[P]),
			.delay_ms  (blank_reg[g]),
			.fault     (aux_fault[P] && port_mode(P, mode_reg) == iocm_pkg::MODE_OUTPUT),
			.armed     (armed[P]),
			.diag_evt  (evt[P])
		);

		a_edge_blanks: assert property (@(posedge aclk) disable iff (!aresetn)
			$changed(aux_supply_pin[P]) |-> !armed[P])
			else $error("monitoring armed on an output edge");
		a_zero_arms: assert property (@(posedge aclk) disable iff (!aresetn)
			($changed(aux_supply_pin[P]) && blank_reg[g] == 8'h00) ##1 $stable(aux_supply_pin[P])
			|-> armed[P])
			else $error("zero delay did not arm monitoring");
		a_blank_event: assert property (@(posedge aclk) disable iff (!aresetn)
			evt[P] |-> armed[P] && aux_fault[P])
			else $error("diagnostic raised while blanked or fault absent");

		sequence s_delayed_edge;
			$changed(aux_supply_pin[P]) && blank_reg[g] != 8'h00;
		endsequence
		a_blank_holds: assert property (@(posedge aclk) disable iff (!aresetn)
			s_delayed_edge |=> !armed[P])
			else $error("monitoring armed before the blanking delay");
		a_fault_persist: assert property (@(posedge aclk) disable iff (!aresetn)
			evt[P] |-> $past(aux_fault[P], 8))
			else $error("diagnostic raised without a persistent fault");
	end

	assign diag_pulse = evt;

	// ----------------------------------------------------------------
	// Pin and setting checks
	// ----------------------------------------------------------------
	a_polarity_pass: assert property (@(posedge aclk) disable iff (!aresetn)
		!FIXED_MODE && !pol_reg[0] |=> input_value[0] == $past(pin_in[0]))
		else $error("normally-open input not passed");
	a_polarity_inv: assert property (@(posedge aclk) disable iff (!aresetn)
		!FIXED_MODE && pol_reg[0] |=> input_value[0] == !$past(pin_in[0]))
		else $error("normally-closed input not inverted");
	a_fixed_aux: assert property (@(posedge aclk) disable iff (!aresetn)
		FIXED_MODE && aresetn |=> aux_supply_pin[7:4] == 4'hF && aux_supply_pin[3:0] == 4'h0)
		else $error("fixed variant aux supply wrong");
	a_reset_blank: assert property (@(posedge aclk)
		!aresetn |=> blank_reg[0] == iocm_pkg::BLANK_RST && pol_reg == 16'h0000)
		else $error("reset settings wrong");
	a_low_port_out: assert property (@(posedge aclk) disable iff (!aresetn)
		!FIXED_MODE && mode_reg[5:4] == 2'h2 |=> !aux_supply_pin[2])
		else $error("output mode on port without aux switch");
	a_out_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		!FIXED_MODE && mode_reg[13:12] == 2'h2 |=> aux_supply_pin[6] == $past(out_reg[6]))
		else $error("switched aux supply does not follow its output bit");
	a_aux_in_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!FIXED_MODE && mode_reg[3:2] != 2'h0 |=> !input_value[9])
		else $error("second channel outside input mode not read as zero");

	a_diag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		(|evt) |=> (diag_reg & $past(evt)) == $past(evt))
		else $error("diagnostic event not latched");
endmodule : iocm_top

// *** testbench/iocm_field.sv ***
`timescale 1ns/1ps
module iocm_field (
	input  wire logic        aclk,                  // Module clock.
	input  wire logic [7:0]  aux_supply_pin,        // Driven aux supply pins.
	input  wire logic [15:0] sensor_level,          // Sensor switch states.
	input  wire logic [7:0]  short_load,            // Ports whose load is shorted.
	output logic      [15:0] pin_in    = 16'h0000,  // Levels at the input pins.
	output logic      [7:0]  aux_fault = 8'h00      // Overcurrent flags.
);
	// A shorted load only draws overcurrent while its pin is really powered.
	always @(posedge aclk) begin
		pin_in    <= sensor_level;
		aux_fault <= short_load & aux_supply_pin;
	end
endmodule : iocm_field

// *** testbench/iocm_top_bench.sv ***
`timescale 1ns/1ps
module iocm_top_bench;
	localparam logic [15:0] PAT = 16'hA5C3;
	localparam logic [15:0] POL = 16'h0104;
	logic        aclk       = 1'b0;
	logic        aresetn    = 1'b0;
	logic [11:0] awaddr     = 12'h000;
	logic [11:0] araddr     = 12'h000;
	logic [31:0] wdata      = 32'h0000_0000;
	logic        awvalid    = 1'b0;
	logic        wvalid     = 1'b0;
	logic        bready     = 1'b0;
	logic        arvalid    = 1'b0;
	logic        rready     = 1'b0;
	logic [15:0] sensor     = 16'h0000;
	logic [7:0]  short_load = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rd_resp, wr_resp;
	logic [31:0] rdata, rd_data;
	logic [15:0] pin_in, inval, fx_val;
	logic [7:0]  aux_pin, aux_fault, diag;
	int          n_mismatch = 0;
	int          compares   = 0;
	int          n_cyc      = 0;
	int          n_pulse    = 0;

	iocm_top #(.MS_CYCLES(4)) i_iocm_top (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF),
		.s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
		.s_rvalid(rvalid), .s_rready(rready), .pin_in(pin_in), .aux_supply_pin(aux_pin),
		.aux_fault(aux_fault), .input_value(inval), .diag_pulse(diag));
	// The small variant shares every input; only its inputs are judged.
	iocm_top #(.MS_CYCLES(4), .FIXED_MODE(1'b1)) i_iocm_top_fixed (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(), .s_wdata(wdata), .s_wstrb(4'hF),
		.s_wvalid(wvalid), .s_wready(), .s_bresp(), .s_bvalid(), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(), .s_rdata(), .s_rresp(),
		.s_rvalid(), .s_rready(rready), .pin_in(pin_in), .aux_supply_pin(),
		.aux_fault(aux_fault), .input_value(fx_val), .diag_pulse());
	iocm_field i_iocm_field (.aclk(aclk), .aux_supply_pin(aux_pin), .sensor_level(sensor),
		.short_load(short_load), .pin_in(pin_in), .aux_fault(aux_fault));

	initial begin
		forever #2.5 aclk = ~aclk;
	end

	// Diag pulses last one cycle; sampling mid-cycle avoids edge races.
	always @(negedge aclk) begin
		if (diag[4] === 1'b1) n_pulse++;
	end

	always @(posedge aclk) begin
		n_cyc++;
		if (n_cyc == 4000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, done;
		done = 1'b0;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!done) begin
			@(negedge aclk);
			ta      = awready;
			tw      = wready;
			done    = bvalid;
			wr_resp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [11:0] a);
		logic ta, done;
		done = 1'b0;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!done) begin
			@(negedge aclk);
			ta      = arready;
			done    = rvalid;
			rd_data = rdata;
			rd_resp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
	endtask : rd

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_pin

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(iocm_pkg::ADDR_POLARITY);
		chk_reg(rd_data, 32'h0000_0000);
		rd(iocm_pkg::ADDR_BLANK0);
		chk_reg(rd_data, {4{iocm_pkg::BLANK_RST}});
		rd(iocm_pkg::ADDR_MODE);
		chk_reg(rd_data, 32'h0000_0000);
	endtask : t_reset

	task automatic t_polarity();
		sensor <= PAT;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk_pin(inval, PAT);
		@(posedge aclk);
		wr(iocm_pkg::ADDR_POLARITY, {16'h0000, POL});
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk_pin(inval, PAT ^ POL);
		@(posedge aclk);
		rd(iocm_pkg::ADDR_INPUT);
		chk_reg(rd_data, {16'h0000, PAT ^ POL});
	endtask : t_polarity

	task automatic t_unmapped();
		rd(12'h0FC);
		chk_reg({rd_data[31:2], rd_resp}, {30'h0, iocm_pkg::RESP_SLVERR});
		wr(12'h0FC, 32'hFFFF_FFFF);
		chk_reg({30'h0, wr_resp}, {30'h0, iocm_pkg::RESP_SLVERR});
	endtask : t_unmapped

	task automatic t_modes();
		wr(iocm_pkg::ADDR_MODE, 32'h0000_E4E4);
		wr(iocm_pkg::ADDR_OUTPUT, 32'h0000_00FF);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk_pin({8'h00, aux_pin & 8'hCC}, 16'h0040);
		chk_pin(inval, (PAT ^ POL) & 16'h11FF);
		chk_pin(fx_val, PAT & 16'h0FFF);
		@(posedge aclk);
		wr(iocm_pkg::ADDR_OUTPUT, 32'h0000_0000);
	endtask : t_modes

	task automatic t_blank();
		wr(iocm_pkg::ADDR_MODE, 32'h0000_0A00);
		wr(iocm_pkg::ADDR_BLANK0, 32'hFF00_0800);
		rd(iocm_pkg::ADDR_BLANK0);
		chk_reg(rd_data, 32'hFF00_0800);
		wr(iocm_pkg::ADDR_OUTPUT, 32'h0000_0030);
		@(posedge aclk);
		rd(iocm_pkg::ADDR_STATUS);
		chk_reg(rd_data & 32'h3030, 32'h0000_3010);
		repeat (16) @(posedge aclk);
		wr(iocm_pkg::ADDR_OUTPUT, 32'h0000_0010);
		repeat (16) @(posedge aclk);
		rd(iocm_pkg::ADDR_STATUS);
		chk_reg(rd_data & 32'h3030, 32'h0000_1010);
		repeat (40) @(posedge aclk);
		rd(iocm_pkg::ADDR_STATUS);
		chk_reg(rd_data & 32'h3030, 32'h0000_1030);
	endtask : t_blank

	task automatic t_diag();
		short_load <= 8'h10;
		repeat (12) @(posedge aclk);
		chk_reg(n_pulse, 32'h0);
		repeat (24) @(posedge aclk);
		chk_reg(n_pulse, 32'h1);
		rd(iocm_pkg::ADDR_DIAG);
		chk_reg(rd_data & 32'hF0, 32'h0000_0010);
		short_load <= 8'h00;
		repeat (2) @(posedge aclk);
		wr(iocm_pkg::ADDR_DIAG, 32'h0000_0010);
		rd(iocm_pkg::ADDR_DIAG);
		chk_reg(rd_data & 32'hF0, 32'h0000_0000);
	endtask : t_diag

	task automatic print_verdict();
		if (n_mismatch == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_polarity();
		t_unmapped();
		t_modes();
		t_blank();
		t_diag();
		print_verdict();
	end
endmodule : iocm_top_bench
